// *** quc_channel.sv ***
// Shared constants of the quad UART host port, plus one channel's register slice.
// Assumes strobes arrive already synchronised and edge-detected as one-cycle pulses on clk_sys.
//
// How it works
// - Separate-select mode drives each channel's active-high interrupt when modem control bit 3 permits.
// - Interrupt sources are receiver errors, received data, transmit empty and modem status.
// - With drive select high the interrupt outputs are driven in separate mode outside reset, modem control bit ignored.
// - With drive select low modem control bit 3 enables outputs; no effect in combined mode.
// - A read strobe returns the addressed register on the data bus; ignored in combined mode.
// - A write strobe stores the data bus into the addressed register, except the status registers at addresses 2, 5 and 6, which ignore writes.
// - Combined mode merges all four channel interrupts onto one request.
// - The combined request is driven low while any enabled source is pending, else released.
// - In separate-select mode a high reset pin clears registers and outputs.
// - Serial transmit and receive stay disabled while reset is active.
// - In combined mode the reset pin has the same effect but is active low.
// - A rising edge on the ring input raises a modem status interrupt.

`timescale 1ns/100ps

package quc_pkg;
	localparam int        CHANNELS    = 4;
	// Register addresses on A0-A2
	localparam logic [2:0] ADDR_HOLD   = 3'h0;
	localparam logic [2:0] ADDR_IRQ_EN = 3'h1;
	localparam logic [2:0] ADDR_ISR    = 3'h2;
	localparam logic [2:0] ADDR_LCR    = 3'h3;
	localparam logic [2:0] ADDR_MODCTL = 3'h4;
	localparam logic [2:0] ADDR_LSR    = 3'h5;
	localparam logic [2:0] ADDR_MSR    = 3'h6;
	localparam logic [2:0] ADDR_SCR    = 3'h7;
	// Field positions
	localparam int        IEN_RXAVAIL = 0;
	localparam int        IEN_TXEMPTY = 1;
	localparam int        IEN_RXERR   = 2;
	localparam int        IEN_MODEM   = 3;
	localparam int        CTL_IRQEN   = 3;
	localparam int        LSR_RXAVAIL = 0;
	localparam int        LSR_RXERR   = 1;
	localparam int        LSR_TXEMPTY = 5;
	localparam int        MSR_RINGUP  = 2;
	localparam int        MSR_RING    = 6;
	// Interrupt identification codes, highest priority first
	localparam logic [7:0] ISR_RXERR   = 8'h06;
	localparam logic [7:0] ISR_RXAVAIL = 8'h04;
	localparam logic [7:0] ISR_TXEMPTY = 8'h02;
	localparam logic [7:0] ISR_MODEM   = 8'h00;
	localparam logic [7:0] ISR_NONE    = 8'h01;
	localparam logic [7:0] REG_RESET   = 8'h00;
	// Positions in the top-level synchroniser vector
	localparam int        SY_RD       = 0;
	localparam int        SY_WR       = 1;
	localparam int        SY_CS       = 2;
	localparam int        SY_ADDR     = 6;
	localparam int        SY_DATA     = 11;
	localparam int        SY_MODE     = 19;
	localparam int        SY_SEL      = 20;
	localparam int        SY_RST      = 21;
	localparam int        SY_W        = 22;
endpackage : quc_pkg

module quc_channel import quc_pkg::*; (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       devReset,
	input  wire logic       ringPin_n,
	input  wire logic       rxError,
	input  wire logic       rxAvail,
	input  wire logic       txEmpty,
	input  wire logic       wrEvent,
	input  wire logic       rdEvent,
	input  wire logic [2:0] regAddr,
	input  wire logic [7:0] wrData,
	output logic      [7:0] regValue,
	output logic            pending,
	output logic            irqEnable
);
	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [7:0] holdReg;
		logic [7:0] irqEnableReg;
		logic [7:0] lcr;
		logic [7:0] modemCtrlReg;
		logic [7:0] scratch;
		logic       ringS1;
		logic       ringS2;
		logic       ringPrev;
		logic       msFlag;
	} quc_chan_type;

	quc_chan_type r;
	quc_chan_type next_r;
	logic         ringRise;
	logic [7:0]   isrCode;

	// Rising ring edge seen on the second synchroniser stage only
	assign ringRise = r.ringS2 & ~r.ringPrev;

	// Enabled pending sources; line status inputs are live, only the ring flag holds until a modem status read
	always_comb begin
		pending = (r.irqEnableReg[IEN_RXERR] & rxError) | (r.irqEnableReg[IEN_RXAVAIL] & rxAvail)
			| (r.irqEnableReg[IEN_TXEMPTY] & txEmpty) | (r.irqEnableReg[IEN_MODEM] & r.msFlag);
		if (r.irqEnableReg[IEN_RXERR] & rxError) begin
			isrCode = ISR_RXERR;
		end else if (r.irqEnableReg[IEN_RXAVAIL] & rxAvail) begin
			isrCode = ISR_RXAVAIL;
		end else if (r.irqEnableReg[IEN_TXEMPTY] & txEmpty) begin
			isrCode = ISR_TXEMPTY;
		end else if (r.irqEnableReg[IEN_MODEM] & r.msFlag) begin
			isrCode = ISR_MODEM;
		end else begin
			isrCode = ISR_NONE;
		end
	end

	assign irqEnable = r.modemCtrlReg[CTL_IRQEN];

	// Read mux; status registers show live block state
	always_comb begin
		regValue = REG_RESET;
		unique case (regAddr)
			ADDR_HOLD: regValue = r.holdReg;
			ADDR_IRQ_EN: regValue = r.irqEnableReg;
			ADDR_ISR:  regValue = isrCode;
			ADDR_LCR:  regValue = r.lcr;
			ADDR_MODCTL: regValue = r.modemCtrlReg;
			ADDR_LSR: begin
				regValue[LSR_RXAVAIL] = rxAvail;
				regValue[LSR_RXERR]   = rxError;
				regValue[LSR_TXEMPTY] = txEmpty;
			end
			ADDR_MSR: begin
				regValue[MSR_RINGUP] = r.msFlag;
				regValue[MSR_RING]   = ~r.ringS2;
			end
			ADDR_SCR:  regValue = r.scratch;
		endcase
	end

	// Next state: writes, ring flag with set winning over read-clear
	always_comb begin
		next_r          = r;
		next_r.ringS1   = ringPin_n;
		next_r.ringS2   = r.ringS1;
		next_r.ringPrev = r.ringS2;
		if (wrEvent) begin
			unique case (regAddr)
				ADDR_HOLD: next_r.holdReg = wrData;
				ADDR_IRQ_EN: next_r.irqEnableReg = wrData;
				ADDR_LCR:    next_r.lcr          = wrData;
				ADDR_MODCTL: next_r.modemCtrlReg = wrData;
				ADDR_SCR:  next_r.scratch = wrData;
				default:   next_r.holdReg = r.holdReg;
			endcase
		end
		if (rdEvent && regAddr == ADDR_MSR) begin
			next_r.msFlag = 1'b0;
		end
		if (ringRise) begin
			next_r.msFlag = 1'b1;
		end
		if (devReset) begin
			next_r.holdReg = REG_RESET;
			next_r.irqEnableReg = REG_RESET;
			next_r.lcr          = REG_RESET;
			next_r.modemCtrlReg = REG_RESET;
			next_r.scratch = REG_RESET;
			next_r.msFlag  = 1'b0;
		end
	end

	// Ring stages reset to idle high so release does not fake an edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r          <= '0;
			r.ringS1   <= 1'b1;
			r.ringS2   <= 1'b1;
			r.ringPrev <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_irqen_write: assert property (wrEvent && regAddr == ADDR_IRQ_EN && !devReset
		|=> r.irqEnableReg == $past(wrData))
		else $error("enable register did not take write");
	a_ring_flag: assert property (ringRise && !devReset
		|=> r.msFlag && (regValue[MSR_RINGUP] || regAddr != ADDR_MSR))
		else $error("ring rise did not set modem flag");
	a_pend_hold: assert property (r.msFlag && !devReset && !(rdEvent && regAddr == ADDR_MSR) |=> r.msFlag)
		else $error("modem flag dropped without status read");
	a_reset_clear: assert property (devReset |=> r.irqEnableReg == REG_RESET && r.modemCtrlReg == REG_RESET
		&& !r.msFlag)
		else $error("reset left channel registers set");
	c_ring_irq: cover property (ringRise ##1 pending);
endmodule : quc_channel

// *** quc_host_port.sv ***
// Host strobe port, reset handling and interrupt outputs of a four-channel UART.
// Assumes all host pins are asynchronous to clk_sys and held stable across a strobe.

`timescale 1ns/100ps

module quc_host_port import quc_pkg::*; (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       resetPin,
	input  wire logic       busMode68,
	input  wire logic       irqDriveSelect,
	input  wire logic       hostReadStrobe_n,
	input  wire logic       hostWriteStrobe_n,
	input  wire logic [3:0] channelSelect_n,
	input  wire logic [4:0] hostAddr,
	input  wire logic [7:0] hostDataIn,
	output logic      [7:0] hostDataOut,
	output logic            hostDataOe_n,
	input  wire logic [3:0] ringPin_n,
	input  wire logic [3:0] rxError,
	input  wire logic [3:0] rxAvail,
	input  wire logic [3:0] txEmpty,
	output logic      [3:0] channelIrqOut,
	output logic      [3:0] channelIrqOe_n,
	output logic            irqReqOut,
	output logic            irqReqOe_n,
	output logic      [3:0] txEnable,
	output logic      [3:0] rxEnable
);
	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [SY_W-1:0] s1;
		logic [SY_W-1:0] s2;
		logic            rdPrev;
		logic            wrPrev;
		logic            csPrev;
		logic            dataDrive;
		logic [7:0]      dataOut;
		logic            serialOn;
	} quc_port_type;

	quc_port_type r;
	quc_port_type next_r;

	logic       rdS;
	logic       wrS;
	logic [3:0] csS;
	logic [4:0] addrS;
	logic [7:0] dataS;
	logic       mode68;
	logic       selS;
	logic       devReset;
	logic       anyCs;
	logic [1:0] chan16;
	logic [1:0] chan;
	logic       csFall;
	logic       rdEv;
	logic       wrEv;
	logic       readActive;
	logic [3:0] pend;
	logic [3:0] ctrlIrqEn;
	logic [7:0] chanReg [CHANNELS];

	// Every host pin passes two flops; logic reads the second stage only
	assign rdS    = r.s2[SY_RD];
	assign wrS    = r.s2[SY_WR];
	assign csS    = r.s2[SY_CS +: 4];
	assign addrS  = r.s2[SY_ADDR +: 5];
	assign dataS  = r.s2[SY_DATA +: 8];
	assign mode68 = r.s2[SY_MODE];
	assign selS   = r.s2[SY_SEL];

	// Reset pin polarity follows the bus mode
	assign devReset = mode68 ? ~r.s2[SY_RST] : r.s2[SY_RST];

	// ************************************************************
	// Strobe decode
	// ************************************************************
	// Lowest selected channel wins if the host selects several at once
	always_comb begin
		chan16 = 2'd0;
		for (int i = CHANNELS - 1; i >= 0; i--) begin
			if (!csS[i]) begin
				chan16 = 2'(i);
			end
		end
	end

	assign anyCs  = ~&csS;
	assign chan   = mode68 ? addrS[4:3] : chan16;
	assign csFall = r.csPrev & ~csS[0];

	// Separate strobes act on their falling edge; combined mode uses the select edge and R/W level
	always_comb begin
		if (mode68) begin
			rdEv       = csFall & wrS;
			wrEv       = csFall & ~wrS;
			readActive = ~csS[0] & wrS;
		end else begin
			rdEv       = r.rdPrev & ~rdS & anyCs;
			wrEv       = r.wrPrev & ~wrS & anyCs;
			readActive = ~rdS & anyCs;
		end
	end

	// ************************************************************
	// Channels
	// ************************************************************
	for (genvar g = 0; g < CHANNELS; g++) begin : gChan
		quc_channel uChan (
			.clk_sys   (clk_sys),
			.rst_n     (rst_n),
			.devReset  (devReset),
			.ringPin_n (ringPin_n[g]),
			.rxError   (rxError[g]),
			.rxAvail   (rxAvail[g]),
			.txEmpty   (txEmpty[g]),
			.wrEvent   (wrEv && chan == 2'(g)),
			.rdEvent   (rdEv && chan == 2'(g)),
			.regAddr   (addrS[2:0]),
			.wrData    (dataS),
			.regValue  (chanReg[g]),
			.pending   (pend[g]),
			.irqEnable (ctrlIrqEn[g])
		);
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_r        = r;
		next_r.s1     = {resetPin, irqDriveSelect, busMode68, hostDataIn, hostAddr,
			channelSelect_n, hostWriteStrobe_n, hostReadStrobe_n};
		next_r.s2     = r.s1;
		next_r.rdPrev = rdS;
		next_r.wrPrev = wrS;
		next_r.csPrev = csS[0];
		// Read data is captured once per strobe and held while the strobe stays asserted
		if (rdEv) begin
			next_r.dataOut   = chanReg[chan];
			next_r.dataDrive = 1'b1;
		end else if (!readActive) begin
			next_r.dataDrive = 1'b0;
		end
		next_r.serialOn = ~devReset;
		if (devReset) begin
			next_r.dataDrive = 1'b0;
			next_r.dataOut   = REG_RESET;
		end
	end

	// Strobe history and the strobe and select bits of both synchroniser stages reset to idle high so release is not mistaken for an edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			r                  <= '0;
			r.rdPrev           <= 1'b1;
			r.wrPrev           <= 1'b1;
			r.csPrev           <= 1'b1;
			r.s1[SY_RD]        <= 1'b1;
			r.s1[SY_WR]        <= 1'b1;
			r.s1[SY_CS +: 4]   <= 4'hf;
			r.s2[SY_RD]        <= 1'b1;
			r.s2[SY_WR]        <= 1'b1;
			r.s2[SY_CS +: 4]   <= 4'hf;
		end else begin
			r <= next_r;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign hostDataOut  = r.dataOut;
	assign hostDataOe_n = ~r.dataDrive;
	assign txEnable     = {CHANNELS{r.serialOn}};
	assign rxEnable     = {CHANNELS{r.serialOn}};

	// Per-channel outputs are three-state; the combined request is open drain, low only
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			channelIrqOut[i]  = pend[i];
			channelIrqOe_n[i] = mode68 | ~(selS | ctrlIrqEn[i]) | devReset;
		end
		irqReqOut  = 1'b0;
		irqReqOe_n = ~(mode68 & |pend & ~devReset);
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_read_data: assert property (rdEv && !devReset |=> hostDataOut == $past(chanReg[chan]) && !hostDataOe_n)
		else $error("read did not return addressed register");
	a_read_mode68: assert property (mode68 && $stable(mode68) && csS[0] |=> hostDataOe_n)
		else $error("data bus driven in combined mode without select");
	a_irq_gate: assert property (!mode68 && !selS && !ctrlIrqEn[0] |-> channelIrqOe_n[0])
		else $error("interrupt driven without enable bit");
	a_irq_forced: assert property (!mode68 && selS && !devReset |-> !channelIrqOe_n[1]
		&& channelIrqOut[1] == pend[1])
		else $error("drive select did not force interrupt output");
	a_irq_follow: assert property (!mode68 && ctrlIrqEn[2] && !devReset |-> channelIrqOut[2] == pend[2]
		&& !channelIrqOe_n[2])
		else $error("channel interrupt does not follow pending");
	a_irq_merge: assert property (mode68 && !devReset && |pend |-> !irqReqOe_n)
		else $error("combined request not driven low");
	a_irq_release: assert property (!mode68 || !(|pend) |-> irqReqOe_n)
		else $error("combined request driven without cause");
	a_serial_off: assert property (devReset |=> txEnable == 4'h0 && rxEnable == 4'h0)
		else $error("serial enabled during reset");
	a_strobe_hold: assert property (rdEv ##1 (readActive && !devReset) [*2] |-> !hostDataOe_n)
		else $error("read data dropped while strobe held");
	c_read16: cover property (!mode68 && rdEv ##1 !hostDataOe_n);
	c_write68: cover property (mode68 && wrEv);
	c_merged_irq: cover property (mode68 && !irqReqOe_n);
endmodule : quc_host_port

// *** quc_host_model.sv ***
// Host processor model for the strobe port of the quad UART.
// Assumes one caller at a time and clk_sys from the bench.
`timescale 1ns/100ps

// ****************************************
// Host bus driver
// ****************************************
module quc_host_model (
	input  wire logic       clk_sys,
	input  wire logic       busMode68,
	input  wire logic [7:0] devData,
	input  wire logic       devDataOe_n,
	output logic            rdStb_n,
	output logic            wrStb_n,
	output logic      [3:0] sel_n,
	output logic      [4:0] addr,
	output logic      [7:0] wrData
);
	logic timedOut;

	// Idle bus: strobes and selects high
	initial begin
		rdStb_n  = 1'b1;
		wrStb_n  = 1'b1;
		sel_n    = 4'hf;
		addr     = 5'h00;
		wrData   = 8'h00;
		timedOut = 1'b0;
	end

	// One byte transfer; stray also pulls the read strobe, which combined mode must ignore
	task automatic xfer(input logic [1:0] ch, input logic [2:0] ra, input logic wr,
		input logic [7:0] wd, input logic stray, output logic [7:0] rd, output logic drove);
		int n;
		logic done;
		rd = 8'h00;
		drove = 1'b0;
		done = 1'b0;
		@(posedge clk_sys) #1;
		addr = {ch, ra};
		wrData = wd;
		wrStb_n = busMode68 ? ~wr : 1'b1;
		// Address settles a cycle before the strobe falls
		@(posedge clk_sys) #1;
		if (busMode68) begin
			sel_n = 4'he;
			rdStb_n = ~stray;
		end else begin
			sel_n = ~(4'h1 << ch);
			if (wr) begin
				wrStb_n = 1'b0;
			end else begin
				rdStb_n = 1'b0;
			end
		end
		// Hold at least four cycles and, for reads, until data is driven
		for (n = 1; n <= 12 && !done; n++) begin
			@(posedge clk_sys);
			if (devDataOe_n === 1'b0) begin
				rd = devData;
				drove = 1'b1;
			end
			done = (n >= 4) && (wr || drove);
		end
		if (!done) begin
			timedOut = 1'b1;
		end
		#1;
		rdStb_n = 1'b1;
		wrStb_n = 1'b1;
		sel_n = 4'hf;
		wrData = ~wd; // Released bus shows the inverse
		addr = ~addr;
		// Return just after an edge so callers never sample in the launching time step
		repeat (5) @(posedge clk_sys);
		#1;
	endtask : xfer
endmodule : quc_host_model

// *** quad_uart_host_strobe_irq_port_tb_top.sv ***
// Self-checking bench for the quad UART host port.
// Assumes quc_pkg and quc_host_port are compiled first.
`timescale 1ns/100ps

// ****************************************
// Bench top
// ****************************************
module quad_uart_host_strobe_irq_port_tb_top import quc_pkg::*;;
	logic       clk_sys, rst_n, resetPin, busMode68, irqDriveSelect;
	logic       rdStb_n, wrStb_n, dataOe_n, irqReqOut, irqReqOe_n, drove;
	logic [3:0] sel_n, ringPin_n, rxError, rxAvail, txEmpty, irqOut, irqOe_n, txEnable, rxEnable;
	logic [4:0] addr;
	logic [7:0] wrData, dataOut, rd;
	int         n_mismatch, check_count;

	quc_host_port u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .resetPin(resetPin), .busMode68(busMode68),
		.irqDriveSelect(irqDriveSelect), .hostReadStrobe_n(rdStb_n), .hostWriteStrobe_n(wrStb_n),
		.channelSelect_n(sel_n), .hostAddr(addr), .hostDataIn(wrData), .hostDataOut(dataOut),
		.hostDataOe_n(dataOe_n), .ringPin_n(ringPin_n), .rxError(rxError), .rxAvail(rxAvail),
		.txEmpty(txEmpty), .channelIrqOut(irqOut), .channelIrqOe_n(irqOe_n), .irqReqOut(irqReqOut),
		.irqReqOe_n(irqReqOe_n), .txEnable(txEnable), .rxEnable(rxEnable));
	quc_host_model u_host (.clk_sys(clk_sys), .busMode68(busMode68), .devData(dataOut),
		.devDataOe_n(dataOe_n), .rdStb_n(rdStb_n), .wrStb_n(wrStb_n), .sel_n(sel_n),
		.addr(addr), .wrData(wrData));

	// Free-running 250 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	// Verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finish_test

	// Single comparison point
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : idle

	// Bus access; a hung handshake ends the run
	task automatic acc(input logic [1:0] ch, input logic [2:0] ra, input logic wr, input logic [7:0] wd,
		input logic stray);
		u_host.xfer(ch, ra, wr, wd, stray, rd, drove);
		if (u_host.timedOut) begin
			n_mismatch++;
			finish_test();
		end
	endtask : acc

	task automatic wrReg(input logic [1:0] ch, input logic [2:0] ra, input logic [7:0] wd);
		acc(ch, ra, 1'b1, wd, 1'b0);
		chk("write drives bus", 8'(drove), 8'h00);
	endtask : wrReg

	task automatic rdReg(input logic [1:0] ch, input logic [2:0] ra, input logic [7:0] exp);
		acc(ch, ra, 1'b0, 8'h00, 1'b0);
		chk("read data", rd, exp);
	endtask : rdReg

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic tReset();
		for (int c = 0; c < 4; c++) begin
			rdReg(2'(c), ADDR_IRQ_EN, REG_RESET);
			rdReg(2'(c), ADDR_MODCTL, REG_RESET);
			rdReg(2'(c), ADDR_ISR, ISR_NONE);
		end
		chk("irq oe", 8'(irqOe_n), 8'h0f);
	endtask : tReset

	// Scratch and control bytes land only in the selected channel
	task automatic tRegs();
		for (int c = 0; c < 4; c++) begin
			wrReg(2'(c), ADDR_SCR, 8'ha0 | 8'(c));
			wrReg(2'(c), ADDR_LCR, 8'h5c ^ 8'(c));
		end
		for (int c = 0; c < 4; c++) begin
			rdReg(2'(c), ADDR_SCR, 8'ha0 | 8'(c));
			rdReg(2'(c), ADDR_LCR, 8'h5c ^ 8'(c));
		end
	endtask : tRegs

	// Each level source masked, then enabled, then two overlapping
	task automatic tSources();
		logic [7:0] code [3] = '{ISR_RXAVAIL, ISR_TXEMPTY, ISR_RXERR};
		wrReg(2'd1, ADDR_MODCTL, 8'h08);
		for (int i = 0; i < 3; i++) begin
			wrReg(2'd1, ADDR_IRQ_EN, 8'h00);
			rxAvail[1] = (i == 0);
			txEmpty[1] = (i == 1);
			rxError[1] = (i == 2);
			idle(4);
			chk("masked irq", 8'(irqOut[1]), 8'h00);
			wrReg(2'd1, ADDR_IRQ_EN, 8'h01 << i);
			chk("irq", 8'(irqOut[1]), 8'h01);
			chk("irq oe", 8'(irqOe_n[1]), 8'h00);
			rdReg(2'd1, ADDR_ISR, code[i]);
		end
		rxAvail[1] = 1'b1;
		wrReg(2'd1, ADDR_IRQ_EN, 8'h07);
		rxError[1] = 1'b0;
		idle(4);
		chk("irq held", 8'(irqOut[1]), 8'h01);
		rdReg(2'd1, ADDR_LSR, 8'h01);
		rxAvail[1] = 1'b0;
		idle(4);
		chk("irq gone", 8'(irqOut[1]), 8'h00);
	endtask : tSources

	// Ring rising edge latches, read of modem status clears
	task automatic tRing();
		wrReg(2'd2, ADDR_MODCTL, 8'h08);
		wrReg(2'd2, ADDR_IRQ_EN, 8'h08);
		ringPin_n[2] = 1'b0;
		idle(5);
		chk("ring fall", 8'(irqOut[2]), 8'h00);
		ringPin_n[2] = 1'b1;
		idle(5);
		chk("ring rise", 8'(irqOut[2]), 8'h01);
		rdReg(2'd2, ADDR_MSR, 8'h04);
		chk("ring cleared", 8'(irqOut[2]), 8'h00);
	endtask : tRing

	task automatic tSelect();
		wrReg(2'd0, ADDR_IRQ_EN, 8'h01);
		rxAvail[0] = 1'b1;
		idle(4);
		chk("gated oe", 8'(irqOe_n[0]), 8'h01);
		irqDriveSelect = 1'b1;
		idle(4);
		chk("forced oe", 8'(irqOe_n), 8'h00);
		chk("forced irq", 8'(irqOut[0]), 8'h01);
		rxAvail[0] = 1'b0;
	endtask : tSelect

	// Reset pin active high in separate mode, releasing the outputs that drive select forces on
	task automatic tPinReset();
		resetPin = 1'b1;
		idle(6);
		chk("tx en", 8'(txEnable), 8'h00);
		chk("rx en", 8'(rxEnable), 8'h00);
		chk("irq oe rst", 8'(irqOe_n), 8'h0f);
		resetPin = 1'b0;
		idle(6);
		chk("tx en", 8'(txEnable), 8'h0f);
		chk("rx en", 8'(rxEnable), 8'h0f);
		rdReg(2'd1, ADDR_IRQ_EN, REG_RESET);
		rdReg(2'd3, ADDR_SCR, REG_RESET);
		irqDriveSelect = 1'b0;
	endtask : tPinReset

	// Combined mode: merged request, stray read strobe, low reset
	task automatic tCombined();
		busMode68 = 1'b1;
		resetPin = 1'b1;
		irqDriveSelect = 1'b1;
		idle(6);
		acc(2'd3, ADDR_SCR, 1'b1, 8'h3c, 1'b1);
		chk("stray read", 8'(drove), 8'h00);
		rdReg(2'd3, ADDR_SCR, 8'h3c);
		chk("req idle", 8'(irqReqOe_n), 8'h01);
		wrReg(2'd3, ADDR_IRQ_EN, 8'h02);
		txEmpty[3] = 1'b1;
		idle(4);
		chk("req", 8'(irqReqOe_n), 8'h00);
		chk("req level", 8'(irqReqOut), 8'h00);
		chk("chan oe off", 8'(irqOe_n), 8'h0f);
		resetPin = 1'b0;
		idle(6);
		chk("tx en", 8'(txEnable), 8'h00);
		resetPin = 1'b1;
		idle(6);
		chk("req cleared", 8'(irqReqOe_n), 8'h01);
		rdReg(2'd3, ADDR_IRQ_EN, REG_RESET);
	endtask : tCombined

	// Main sequence
	initial begin
		n_mismatch = 0;
		check_count = 0;
		rst_n = 1'b0;
		resetPin = 1'b0;
		busMode68 = 1'b0;
		irqDriveSelect = 1'b0;
		ringPin_n = 4'hf;
		rxError = 4'h0;
		rxAvail = 4'h0;
		txEmpty = 4'h0;
		idle(16);
		rst_n = 1'b1;
		idle(4);
		tReset();
		tRegs();
		tSources();
		tRing();
		tSelect();
		tPinReset();
		tCombined();
		finish_test();
	end
endmodule : quad_uart_host_strobe_irq_port_tb_top
